// >>> rtl/ddrcd_decode.sv
`timescale 1ns/1ns
module ddrcd_decode
  import ddrcd_pkg::*;
#(
  parameter int BURST_LEN = 4 // Beats per read or write burst
) (
  input wire logic core_clk, // Device clock, commands sampled on rising edge
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic clkEnable, // Clock enable pin
  input wire logic chipSelN, // Chip select, active low
  input wire logic rowStrobeN, // Row strobe, active low
  input wire logic colStrobeN, // Column strobe, active low
  input wire logic writeStrobeN, // Write strobe, active low
  input wire logic [ADDR_W-1:0] addr, // Address lines
  input wire logic [BANK_W-1:0] bankSelect, // Bank select lines
  input wire logic [LANES-1:0] writeByteMask, // Bit 0 lower, bit 1 upper byte mask
  input wire logic [LANES-1:0] dataStrobeIn, // Strobe pin input, bit 0 lower lane
  output logic [LANES-1:0] dataStrobeOut, // Strobe pin output
  output logic [LANES-1:0] dataStrobeOe, // Strobe pin output enable
  input wire logic [DQ_W-1:0] dqIn, // Data pin input
  output logic [DQ_W-1:0] dqOut, // Data pin output
  output logic dqOe, // Data pin output enable
  output logic [LANES-1:0] strobeFifoReady, // Lane buffer has room, strobe domain
  output logic arrRdEn, // Array read of one beat
  output logic arrWrEn, // Array write of one beat pair
  output logic [BANK_W-1:0] arrBank, // Array bank
  output logic [ADDR_W-1:0] arrRow, // Array row
  output logic [COL_W-1:0] arrCol, // Array column of first beat
  output logic [2*DQ_W-1:0] arrWrData, // Second beat high, first beat low
  output logic [2*LANES-1:0] arrByteEn, // Byte enables matching arrWrData
  input wire logic [DQ_W-1:0] arrRdData, // Read beat, sampled in the same cycle as arrRdEn
  input wire logic arrReady, // Array accepts a write
  output logic [MODE_W-1:0] modeReg, // Base mode register
  output logic [MODE_W-1:0] extModeReg, // Extended mode register
  output logic [NUM_BANKS-1:0] bankOpen, // Row open per bank
  output logic [1:0] powerState, // Power state code
  output logic refreshPulse // Auto refresh issued
);

  if (BURST_LEN != 2 && BURST_LEN != 4 && BURST_LEN != 8) begin : g_bad_burst
    $error("ddrcd_decode: BURST_LEN must be 2, 4 or 8");
  end

  localparam logic [3:0] READ_BEATS = 4'(BURST_LEN);
  localparam logic [3:0] WRITE_PAIRS = 4'(BURST_LEN / 2);
  localparam int FIFO_W = 2 * BEAT_W;

  function automatic ddrcd_cmd_t decodeCmd(input logic cs, input logic ras,
                                           input logic cas, input logic we);
    if (cs) begin
      decodeCmd = CMD_DESELECT;
    end else begin
      case ({ras, cas, we})
        3'b000: decodeCmd = CMD_LOAD_MODE;
        3'b011: decodeCmd = CMD_ACTIVATE;
        3'b101: decodeCmd = CMD_READ;
        3'b100: decodeCmd = CMD_WRITE;
        3'b010: decodeCmd = CMD_PRECHARGE;
        3'b110: decodeCmd = CMD_BURST_STOP;
        3'b001: decodeCmd = CMD_REFRESH;
        default: decodeCmd = CMD_IDLE;
      endcase
    end
  endfunction : decodeCmd

  function automatic logic isQuiet(input ddrcd_cmd_t c);
    isQuiet = (c == CMD_DESELECT) || (c == CMD_IDLE);
  endfunction : isQuiet

  ddrcd_cmd_t cmd;
  ddrcd_pwr_t pwr_r;
  ddrcd_burst_t burst_r;
  logic ckePrev_r;
  logic live;
  logic [MODE_W-1:0] modeReg_r, extModeReg_r;
  logic [NUM_BANKS-1:0] bankOpen_r;
  logic [ADDR_W-1:0] rows_r [NUM_BANKS];
  logic [3:0] left_r;
  logic [COL_W-1:0] col_r;
  logic [BANK_W-1:0] bank_r;
  logic autoPre_r;
  logic readStep, pop, apClose;
  logic [LANES-1:0] laneValid;
  logic [FIFO_W-1:0] laneWord [LANES];
  logic arrRdEn_r, arrWrEn_r, dqOe_r, strobe_r, refresh_r;
  logic [BANK_W-1:0] arrBank_r;
  logic [ADDR_W-1:0] arrRow_r;
  logic [COL_W-1:0] arrCol_r;
  logic [2*DQ_W-1:0] arrWrData_r;
  logic [2*LANES-1:0] arrByteEn_r;
  logic [DQ_W-1:0] dqOut_r;

  always_comb cmd = decodeCmd(chipSelN, rowStrobeN, colStrobeN, writeStrobeN);

  // Commands count only when enable was high the cycle before and the device is awake
  assign live = ckePrev_r && (pwr_r == PWR_ON);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ckePrev_r <= 1'b0;
    end else begin
      ckePrev_r <= clkEnable;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_r <= PWR_ON;
    end else begin
      case (pwr_r)
        PWR_ON: begin
          if (ckePrev_r && !clkEnable) begin
            if (cmd == CMD_REFRESH) begin
              pwr_r <= PWR_SELF_REFRESH;
            end else if (isQuiet(cmd)) begin
              pwr_r <= (|bankOpen_r) ? PWR_DOWN_ACT : PWR_DOWN_PRE;
            end
          end
        end
        default: begin
          if (!ckePrev_r && clkEnable && isQuiet(cmd)) begin
            pwr_r <= PWR_ON;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeReg_r <= MODE_RESET;
      extModeReg_r <= MODE_RESET;
    end else if (live && cmd == CMD_LOAD_MODE) begin
      if (!bankSelect[0]) begin
        modeReg_r <= {bankSelect, addr};
      end else begin
        extModeReg_r <= {bankSelect, addr};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bankOpen_r <= '0;
    end else begin
      if (apClose) begin
        bankOpen_r[bank_r] <= 1'b0;
      end
      if (live && cmd == CMD_ACTIVATE) begin
        bankOpen_r[bankSelect] <= 1'b1;
      end else if (live && cmd == CMD_PRECHARGE) begin
        if (addr[AP_BIT]) begin
          bankOpen_r <= '0;
        end else begin
          bankOpen_r[bankSelect] <= 1'b0;
        end
      end
    end
  end

  // Row storage has no reset; a row is only read after its bank is activated
  always_ff @(posedge core_clk) begin
    if (live && cmd == CMD_ACTIVATE) begin
      rows_r[bankSelect] <= addr;
    end
  end

  assign readStep = burst_r == BURST_READ;
  assign pop = (burst_r == BURST_WRITE) && (&laneValid) && arrReady;
  assign apClose = (readStep || pop) && (left_r == 4'h1) && autoPre_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_r <= BURST_IDLE;
      left_r <= 4'h0;
      col_r <= '0;
      bank_r <= '0;
      autoPre_r <= 1'b0;
    end else if (live && (cmd == CMD_READ || cmd == CMD_WRITE)) begin
      burst_r <= (cmd == CMD_READ) ? BURST_READ : BURST_WRITE;
      left_r <= (cmd == CMD_READ) ? READ_BEATS : WRITE_PAIRS;
      col_r <= addr[COL_W-1:0];
      bank_r <= bankSelect;
      autoPre_r <= addr[AP_BIT];
    end else if (live && cmd == CMD_BURST_STOP && readStep) begin
      burst_r <= BURST_IDLE;
      left_r <= 4'h0;
    end else if (readStep || pop) begin
      left_r <= left_r - 4'h1;
      col_r <= col_r + (readStep ? COL_W'(1) : COL_W'(2));
      if (left_r == 4'h1) begin
        burst_r <= BURST_IDLE;
      end
    end
  end

  // Each lane captures on its own strobe; the strobe stops between bursts, so
  // its logic only ever pushes whole rise and fall pairs into the lane buffer
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [BEAT_W-1:0] riseBeat_r;
    logic fallClk;

    assign fallClk = ~dataStrobeIn[g];

    always_ff @(posedge dataStrobeIn[g] or negedge rst_n) begin
      if (!rst_n) begin
        riseBeat_r <= '0;
      end else begin
        riseBeat_r <= {writeByteMask[g], dqIn[g*LANE_W +: LANE_W]};
      end
    end

    ddrcd_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(FIFO_DEPTH)
    ) u_lane_fifo (
      .wrClk(fallClk),
      .rdClk(core_clk),
      .rst_n(rst_n),
      .wrValid(1'b1),
      .wrReady(strobeFifoReady[g]),
      .wrData({writeByteMask[g], dqIn[g*LANE_W +: LANE_W], riseBeat_r}),
      .rdValid(laneValid[g]),
      .rdReady(pop),
      .rdData(laneWord[g])
    );
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arrRdEn_r <= 1'b0;
      arrWrEn_r <= 1'b0;
      arrBank_r <= '0;
      arrRow_r <= '0;
      arrCol_r <= '0;
      arrWrData_r <= '0;
      arrByteEn_r <= '0;
    end else begin
      arrRdEn_r <= readStep;
      arrWrEn_r <= pop;
      if (readStep || pop) begin
        arrBank_r <= bank_r;
        arrRow_r <= rows_r[bank_r];
        arrCol_r <= col_r;
      end
      if (pop) begin
        arrWrData_r <= {laneWord[1][FIFO_W-2 -: LANE_W], laneWord[0][FIFO_W-2 -: LANE_W],
                        laneWord[1][LANE_W-1:0], laneWord[0][LANE_W-1:0]};
        arrByteEn_r <= ~{laneWord[1][FIFO_W-1], laneWord[0][FIFO_W-1],
                         laneWord[1][BEAT_W-1], laneWord[0][BEAT_W-1]};
      end
    end
  end

  // Strobe flips with every read beat so each edge lines up with a data change
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dqOut_r <= '0;
      dqOe_r <= 1'b0;
      strobe_r <= 1'b0;
    end else begin
      dqOe_r <= arrRdEn_r;
      if (arrRdEn_r) begin
        dqOut_r <= arrRdData;
        strobe_r <= ~strobe_r;
      end else begin
        strobe_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_r <= 1'b0;
    end else begin
      refresh_r <= live && clkEnable && (cmd == CMD_REFRESH);
    end
  end

  assign dataStrobeOut = {LANES{strobe_r}};
  assign dataStrobeOe = {LANES{dqOe_r}};
  assign dqOut = dqOut_r;
  assign dqOe = dqOe_r;
  assign arrRdEn = arrRdEn_r;
  assign arrWrEn = arrWrEn_r;
  assign arrBank = arrBank_r;
  assign arrRow = arrRow_r;
  assign arrCol = arrCol_r;
  assign arrWrData = arrWrData_r;
  assign arrByteEn = arrByteEn_r;
  assign modeReg = modeReg_r;
  assign extModeReg = extModeReg_r;
  assign bankOpen = bankOpen_r;
  assign powerState = pwr_r;
  assign refreshPulse = refresh_r;

  property p_deselect_ignored;
    @(posedge core_clk) disable iff (!rst_n)
      (chipSelN && live) |=> ($stable(modeReg_r) && $stable(extModeReg_r)
        && (burst_r == $past(burst_r) || burst_r == BURST_IDLE) && ($stable(bankOpen_r) || $past(apClose)));
  endproperty
  a_deselect_ignored: assert property (p_deselect_ignored) else $error("deselect changed state");

  property p_activate_opens;
    @(posedge core_clk) disable iff (!rst_n)
      (live && cmd == CMD_ACTIVATE) |=> bankOpen_r[$past(bankSelect)];
  endproperty
  a_activate_opens: assert property (p_activate_opens) else $error("activate left bank closed");

  property p_precharge_all;
    @(posedge core_clk) disable iff (!rst_n)
      (live && cmd == CMD_PRECHARGE && addr[AP_BIT]) |=> (bankOpen_r == '0);
  endproperty
  a_precharge_all: assert property (p_precharge_all) else $error("precharge all left a bank open");

  property p_precharge_one;
    @(posedge core_clk) disable iff (!rst_n)
      (live && cmd == CMD_PRECHARGE && !addr[AP_BIT] && bankOpen_r != '0)
        |=> (!bankOpen_r[$past(bankSelect)] && ((bankOpen_r | (4'h1 << $past(bankSelect)))
             == ($past(bankOpen_r) | (4'h1 << $past(bankSelect))) || $past(apClose)));
  endproperty
  a_precharge_one: assert property (p_precharge_one) else $error("single precharge hit wrong bank");

  property p_mode_load;
    @(posedge core_clk) disable iff (!rst_n)
      (live && cmd == CMD_LOAD_MODE && !bankSelect[0]) |=> (modeReg_r == $past({bankSelect, addr})
        && $stable(extModeReg_r));
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("base mode load wrong");

  property p_self_refresh;
    @(posedge core_clk) disable iff (!rst_n)
      (live && !clkEnable && cmd == CMD_REFRESH) |=> (pwr_r == PWR_SELF_REFRESH) ##1 (!refresh_r);
  endproperty
  a_self_refresh: assert property (p_self_refresh) else $error("self refresh not entered");

  property p_mask_discard;
    @(posedge core_clk) disable iff (!rst_n)
      pop |=> (arrWrEn && arrByteEn[0] == !$past(laneWord[0][BEAT_W-1])
               && arrByteEn[3] == !$past(laneWord[1][FIFO_W-1]));
  endproperty
  a_mask_discard: assert property (p_mask_discard) else $error("byte enable does not follow mask");

  property p_read_edge_aligned;
    @(posedge core_clk) disable iff (!rst_n)
      arrRdEn_r |=> (dqOe && dqOut == $past(arrRdData) && strobe_r != $past(strobe_r));
  endproperty
  a_read_edge_aligned: assert property (p_read_edge_aligned) else $error("read beat not aligned");

  property p_read_starts;
    @(posedge core_clk) disable iff (!rst_n)
      (live && cmd == CMD_READ) |=> readStep ##1 arrRdEn ##1 dqOe;
  endproperty
  a_read_starts: assert property (p_read_starts) else $error("read burst did not start");

endmodule : ddrcd_decode

// >>> rtl/ddrcd_pkg.sv
package ddrcd_pkg;

  localparam int ADDR_W = 12;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int COL_W = 9;
  localparam int LANES = 2;
  localparam int LANE_W = 8;
  localparam int DQ_W = 16;
  localparam int AP_BIT = 10;
  localparam int MODE_W = ADDR_W + BANK_W;
  localparam int FIFO_DEPTH = 16;
  localparam int BEAT_W = LANE_W + 1;
  localparam logic [MODE_W-1:0] MODE_RESET = 14'h0000;

  typedef enum logic [3:0] {
    CMD_DESELECT,
    CMD_IDLE,
    CMD_LOAD_MODE,
    CMD_ACTIVATE,
    CMD_READ,
    CMD_WRITE,
    CMD_PRECHARGE,
    CMD_BURST_STOP,
    CMD_REFRESH
  } ddrcd_cmd_t;

  typedef enum logic [1:0] {
    PWR_ON,
    PWR_DOWN_PRE,
    PWR_DOWN_ACT,
    PWR_SELF_REFRESH
  } ddrcd_pwr_t;

  typedef enum logic [1:0] {
    BURST_IDLE,
    BURST_READ,
    BURST_WRITE
  } ddrcd_burst_t;

endpackage : ddrcd_pkg

// >>> rtl/ddrcd_fifo.sv
`timescale 1ns/1ns
module ddrcd_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic wrClk, // Filling side clock
  input wire logic rdClk, // Draining side clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic wrValid, // Word offered
  output logic wrReady, // Room for a word
  input wire logic [WIDTH-1:0] wrData, // Word in
  output logic rdValid, // Word available
  input wire logic rdReady, // Word taken
  output logic [WIDTH-1:0] rdData // Word out
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("ddrcd_fifo: DEPTH must be a power of two of at least 4");
  end

  function automatic logic [AW:0] toGray(input logic [AW:0] b);
    toGray = b ^ (b >> 1);
  endfunction : toGray

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrBin_r, wrGray_r, rdBin_r, rdGray_r;
  logic [AW:0] rdSync1_r, rdSync2_r, wrSync1_r, wrSync2_r;
  logic [AW:0] wrBin_nxt, rdBin_nxt;
  logic push, pop;

  // Full compares against a stale read pointer, so it can only err towards full
  assign wrReady = wrGray_r != {~rdSync2_r[AW:AW-1], rdSync2_r[AW-2:0]};
  assign rdValid = rdGray_r != wrSync2_r;
  assign push = wrValid && wrReady;
  assign pop = rdValid && rdReady;
  assign wrBin_nxt = wrBin_r + (AW+1)'(push);
  assign rdBin_nxt = rdBin_r + (AW+1)'(pop);
  assign rdData = mem[rdBin_r[AW-1:0]];

  always_ff @(posedge wrClk) begin
    if (push) begin
      mem[wrBin_r[AW-1:0]] <= wrData;
    end
  end

  always_ff @(posedge wrClk or negedge rst_n) begin
    if (!rst_n) begin
      wrBin_r <= '0;
      wrGray_r <= '0;
      rdSync1_r <= '0;
      rdSync2_r <= '0;
    end else begin
      wrBin_r <= wrBin_nxt;
      wrGray_r <= toGray(wrBin_nxt);
      rdSync1_r <= rdGray_r;
      rdSync2_r <= rdSync1_r;
    end
  end

  always_ff @(posedge rdClk or negedge rst_n) begin
    if (!rst_n) begin
      rdBin_r <= '0;
      rdGray_r <= '0;
      wrSync1_r <= '0;
      wrSync2_r <= '0;
    end else begin
      rdBin_r <= rdBin_nxt;
      rdGray_r <= toGray(rdBin_nxt);
      wrSync1_r <= wrGray_r;
      wrSync2_r <= wrSync1_r;
    end
  end

endmodule : ddrcd_fifo

// >>> verification/ddrcd_ctrl_model.sv
`timescale 1ns/1ns
module ddrcd_ctrl_model
  import ddrcd_pkg::*;
(
  input wire logic linkClk, // Source of the write strobe
  output logic [LANES-1:0] dataStrobeIn, // Strobe to both device lanes
  output logic [DQ_W-1:0] dqIn, // Write data to the device
  output logic [LANES-1:0] writeByteMask // Byte masks to the device
);
  initial begin
    dataStrobeIn = '0;
    dqIn = 16'h0000;
    writeByteMask = 2'h0;
  end

  // One beat pair; the strobe stands still between frames
  task automatic send_pair(input logic [DQ_W-1:0] rise, input logic [DQ_W-1:0] fall,
                           input logic [LANES-1:0] mRise, input logic [LANES-1:0] mFall);
    @(negedge linkClk);
    dqIn = rise;
    writeByteMask = mRise;
    @(posedge linkClk);
    dataStrobeIn = 2'h3;
    @(negedge linkClk);
    dqIn = fall;
    writeByteMask = mFall;
    @(posedge linkClk);
    dataStrobeIn = 2'h0;
    @(negedge linkClk);
    // Released lines must not keep showing the last beat
    dqIn = ~dqIn;
    writeByteMask = ~writeByteMask;
  endtask : send_pair
endmodule : ddrcd_ctrl_model

// >>> verification/test_ddr_dram_command_decode.sv
`timescale 1ns/1ns
module test_ddr_dram_command_decode;
  import ddrcd_pkg::*;
  localparam int BURST_BEATS = 4;
  logic core_clk, linkClk, rst_n, clkEnable, chipSelN, rowStrobeN, colStrobeN, writeStrobeN, dqOe;
  logic arrRdEn, arrWrEn, arrReady, refreshPulse;
  logic [ADDR_W-1:0] addr, arrRow;
  logic [BANK_W-1:0] bankSelect, arrBank;
  logic [LANES-1:0] writeByteMask, dataStrobeIn, dataStrobeOut, dataStrobeOe, strobeFifoReady;
  logic [DQ_W-1:0] dqIn, dqOut, arrRdData;
  logic [COL_W-1:0] arrCol;
  logic [2*DQ_W-1:0] arrWrData;
  logic [2*LANES-1:0] arrByteEn;
  logic [MODE_W-1:0] modeReg, extModeReg, expMode, expExt;
  logic [NUM_BANKS-1:0] bankOpen, expOpen;
  logic [1:0] powerState;
  ddrcd_pwr_t expPwr;
  logic prevCke = 1'b1;
  logic [31:0] seed = 32'h27e599a4;
  int numErrors, totalChecks, expRefresh, gotRefresh, rdIdx, cycleCount;
  logic [DQ_W-1:0] expBeats[$];
  logic [31:0] expPairs[$], pendData[$];
  logic [3:0] expEn[$], pendEn[$];
  logic [BANK_W+ADDR_W+COL_W-1:0] expCols[$];
  logic [ADDR_W-1:0] expRows [NUM_BANKS];

  ddrcd_decode #(.BURST_LEN(BURST_BEATS)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .clkEnable(clkEnable),
    .chipSelN(chipSelN), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeStrobeN(writeStrobeN),
    .addr(addr), .bankSelect(bankSelect), .writeByteMask(writeByteMask), .dataStrobeIn(dataStrobeIn),
    .dataStrobeOut(dataStrobeOut), .dataStrobeOe(dataStrobeOe), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
    .strobeFifoReady(strobeFifoReady), .arrRdEn(arrRdEn), .arrWrEn(arrWrEn), .arrBank(arrBank),
    .arrRow(arrRow), .arrCol(arrCol), .arrWrData(arrWrData), .arrByteEn(arrByteEn), .arrRdData(arrRdData),
    .arrReady(arrReady), .modeReg(modeReg), .extModeReg(extModeReg), .bankOpen(bankOpen),
    .powerState(powerState), .refreshPulse(refreshPulse));
  ddrcd_ctrl_model i_ctrl (.linkClk(linkClk), .dataStrobeIn(dataStrobeIn), .dqIn(dqIn),
    .writeByteMask(writeByteMask));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    linkClk = 1'b0;
    #5;
    forever #6 linkClk = ~linkClk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check_state(input logic [31:0] got, input logic [31:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_state

  task automatic check_data(input logic [31:0] got, input logic [31:0] exp, input logic [3:0] en,
                            input string what);
    logic [31:0] m;
    m = {{8{en[3]}}, {8{en[2]}}, {8{en[1]}}, {8{en[0]}}};
    totalChecks++;
    if ((got & m) !== (exp & m)) begin
      numErrors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_data

  task automatic complete_run();
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Issues one command {cs, row, col, write}, updates the reference model, then compares state
  task automatic cmd(input logic [3:0] csrcw, input logic [BANK_W-1:0] ba, input logic [ADDR_W-1:0] a,
                     input logic cke);
    @(posedge core_clk);
    {chipSelN, rowStrobeN, colStrobeN, writeStrobeN} <= csrcw;
    bankSelect <= ba;
    addr <= a;
    clkEnable <= cke;
    if (expPwr != PWR_ON) begin
      if (!prevCke && cke && (csrcw[3] || csrcw == 4'h7)) expPwr = PWR_ON;
    end else if (prevCke && !cke && csrcw == 4'h1) begin
      expPwr = PWR_SELF_REFRESH;
    end else if (prevCke && !cke && (csrcw[3] || csrcw == 4'h7)) begin
      expPwr = (expOpen != 0) ? PWR_DOWN_ACT : PWR_DOWN_PRE;
    end else if (prevCke && !csrcw[3]) begin
      case (csrcw[2:0])
        3'h0: if (ba[0]) expExt = {ba, a}; else expMode = {ba, a};
        3'h3: begin
          expOpen[ba] = 1'b1;
          expRows[ba] = a;
        end
        3'h2: if (a[AP_BIT]) expOpen = '0; else expOpen[ba] = 1'b0;
        3'h1: expRefresh++;
        3'h5: begin
          for (int j = 0; j < BURST_BEATS; j++) expBeats.push_back({ba, a[8:0] + 9'(j), 5'h15});
          if (a[AP_BIT]) expOpen[ba] = 1'b0;
        end
        3'h4: begin
          for (int j = 0; j < BURST_BEATS / 2; j++) begin
            expPairs.push_back(pendData.pop_front());
            expEn.push_back(pendEn.pop_front());
            expCols.push_back({ba, expRows[ba], a[8:0] + 9'(2 * j)});
          end
          if (a[AP_BIT]) expOpen[ba] = 1'b0;
        end
        default: ;
      endcase
    end
    prevCke = cke;
    @(posedge core_clk);
    {chipSelN, rowStrobeN, colStrobeN, writeStrobeN} <= 4'h7;
    addr <= ADDR_W'(rnd());
    bankSelect <= BANK_W'(rnd());
    repeat (4) @(posedge core_clk);
    for (int n = 0; n < 200 && (expBeats.size() + expPairs.size()) > 0; n++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    #1;
    check_state(32'(bankOpen), 32'(expOpen), "open banks");
    check_state(32'(powerState), 32'(expPwr), "power state");
    check_state(32'({extModeReg, modeReg}), 32'({expExt, expMode}), "mode registers");
    check_state(32'(gotRefresh), 32'(expRefresh), "refresh count");
  endtask : cmd

  // Array side: read beat stands while its request does, random write stalls
  always @(posedge core_clk) begin
    arrReady <= rnd() > 32'h40000000;
  end
  // Off beats show the inverse so a stale sample cannot match
  assign arrRdData = (arrRdEn === 1'b1) ? {arrBank, arrCol, 5'h15} : ~{arrBank, arrCol, 5'h15};

  always @(posedge core_clk) begin
    logic [3:0] en;
    cycleCount++;
    if (refreshPulse === 1'b1) gotRefresh++;
    if (dqOe !== 1'b1) begin
      rdIdx <= 0;
    end else begin
      if (expBeats.size() == 0) check_state(32'h1, 32'h0, "unexpected read beat");
      else check_data({16'h0, dqOut}, {16'h0, expBeats.pop_front()}, 4'h3, "read beat");
      check_state(32'({dataStrobeOe, dataStrobeOut}), 32'({2'h3, {2{rdIdx[0] == 1'b0}}}), "strobe");
      rdIdx <= rdIdx + 1;
    end
    if (rst_n && arrWrEn === 1'b1) begin
      if (expPairs.size() == 0) begin
        check_state(32'h1, 32'h0, "unexpected write pair");
      end else begin
        en = expEn.pop_front();
        check_data(arrWrData, expPairs.pop_front(), en, "write pair");
        check_state(32'(arrByteEn), 32'(en), "byte enables");
        check_state(32'({arrBank, arrRow, arrCol}), 32'(expCols.pop_front()), "write address");
      end
    end
    if (cycleCount == 20000) begin
      numErrors++;
      $display("mismatch at %0t: run did not finish", $time);
      complete_run();
    end
  end

  initial begin
    logic [31:0] r;
    rst_n = 1'b0;
    clkEnable = 1'b1;
    {chipSelN, rowStrobeN, colStrobeN, writeStrobeN} = 4'hf;
    addr = '0;
    bankSelect = '0;
    arrReady = 1'b1;
    expOpen = '0;
    expMode = MODE_RESET;
    expExt = MODE_RESET;
    expPwr = PWR_ON;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    cmd(4'h7, 2'h0, 12'h000, 1'b1);
    for (int i = 0; i < 4; i++) cmd(4'h0, BANK_W'(i), ADDR_W'(rnd()), 1'b1);
    for (int i = 0; i < NUM_BANKS; i++) cmd(4'h3, BANK_W'(i), ADDR_W'(rnd()), 1'b1);
    cmd(4'h2, 2'h1, 12'h000, 1'b1);
    cmd(4'h2, 2'h2, 12'h400, 1'b1);
    cmd(4'hb, 2'h0, 12'h000, 1'b1);
    cmd(4'h1, 2'h0, 12'h000, 1'b1);
    cmd(4'h6, 2'h0, 12'h000, 1'b1);
    cmd(4'h3, 2'h2, ADDR_W'(rnd()), 1'b1);
    for (int i = 0; i < 2; i++) cmd(4'h5, 2'h2, {1'b0, 1'(i), 1'b0, 7'(rnd()), 2'b00}, 1'b1);
    cmd(4'h3, 2'h0, ADDR_W'(rnd()), 1'b1);
    cmd(4'h7, 2'h0, 12'h000, 1'b0);
    cmd(4'h3, 2'h1, 12'h000, 1'b0);
    cmd(4'hf, 2'h0, 12'h000, 1'b1);
    cmd(4'h2, 2'h0, 12'h400, 1'b1);
    cmd(4'h8, 2'h0, 12'h000, 1'b0);
    cmd(4'h7, 2'h0, 12'h000, 1'b1);
    cmd(4'h1, 2'h0, 12'h000, 1'b0);
    cmd(4'h7, 2'h0, 12'h000, 1'b1);
    cmd(4'h3, 2'h3, ADDR_W'(rnd()), 1'b1);
    // Fill the lane buffers past full with no write burst, then drain them through writes
    for (int p = 0; p <= FIFO_DEPTH; p++) begin
      r = rnd();
      if (p == FIFO_DEPTH) check_state(32'(strobeFifoReady), 32'h0, "lane buffer full");
      i_ctrl.send_pair(r[15:0], r[31:16], r[1:0], r[3:2]);
      if (p < FIFO_DEPTH) begin
        pendData.push_back(r);
        pendEn.push_back(~r[3:0]);
      end
    end
    for (int w = 0; w < FIFO_DEPTH / (BURST_BEATS / 2); w++) begin
      cmd(4'h4, 2'h3, {1'b0, w == FIFO_DEPTH / (BURST_BEATS / 2) - 1, 1'b0, 9'(w * 2 * BURST_BEATS)}, 1'b1);
    end
    check_state(32'(expBeats.size() + expPairs.size()), 32'h0, "results outstanding");
    complete_run();
  end
endmodule : test_ddr_dram_command_decode
